// *** common/dbg_tap_pkg.sv ***
// Constants, state and instruction codes for the debug TAP port
package dbg_tap_pkg;
  localparam int IR_W = 4;
  localparam int SC_W = 5;
  localparam int ID_W = 32;
  localparam int DCR_W = 6;
  localparam int DCR_DBGRQ_BIT = 1;
  localparam logic [3:0] IR_RESET = 4'hE;
  localparam logic [4:0] SC_RESET = 5'h00;
  localparam logic [5:0] DCR_RESET = 6'h00;

  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0,
    ST_EXIT1_DR = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR = 4'h4,
    ST_UPD_DR = 4'h5,
    ST_CAP_DR = 4'h6,
    ST_SEL_DR = 4'h7,
    ST_EXIT2_IR = 4'h8,
    ST_EXIT1_IR = 4'h9,
    ST_SHIFT_IR = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_IDLE = 4'hC,
    ST_UPD_IR = 4'hD,
    ST_CAP_IR = 4'hE,
    ST_RESET = 4'hF
  } tap_state_t;

  typedef enum logic [3:0] {
    INS_EXTEST = 4'h0,
    INS_SCAN_N = 4'h2,
    INS_SAMPLE = 4'h3,
    INS_RESTART = 4'h4,
    INS_CLAMP = 4'h5,
    INS_HIGHZ = 4'h7,
    INS_CLAMPZ = 4'h9,
    INS_INTEST = 4'hC,
    INS_IDCODE = 4'hE,
    INS_BYPASS = 4'hF
  } tap_instr_t;

  localparam logic [4:0] SC_DEBUG_CTRL = 5'h02;
  localparam logic [4:0] SC_EXTERNAL = 5'h04;
endpackage

// *** common/tap_ctrl_if.sv ***
// Signals between the TAP controller and the debug port top
`timescale 1ns/1ps
interface tap_ctrl_if;
  logic step;
  logic [3:0] state;
  modport ctrl (input step, output state);
  modport user (output step, input state);
endinterface

// *** src/tap_fsm.sv ***
// TAP controller state machine, advanced on enabled clock edges
`timescale 1ns/1ps
module tap_fsm (
  input wire logic clk, // System clock
  input wire logic tap_rst_n, // Test reset, active low
  input wire logic mode_select, // Mode select, sampled when stepping
  tap_ctrl_if.ctrl tc // Step in, state out
);
  dbg_tap_pkg::tap_state_t state_ff;
  dbg_tap_pkg::tap_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dbg_tap_pkg::ST_RESET: nxt_state = mode_select ?
        dbg_tap_pkg::ST_RESET : dbg_tap_pkg::ST_IDLE;
      dbg_tap_pkg::ST_IDLE: nxt_state = mode_select ?
        dbg_tap_pkg::ST_SEL_DR : dbg_tap_pkg::ST_IDLE;
      dbg_tap_pkg::ST_SEL_DR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_SEL_IR : dbg_tap_pkg::ST_CAP_DR;
      dbg_tap_pkg::ST_CAP_DR, dbg_tap_pkg::ST_SHIFT_DR:
        nxt_state = mode_select ?
        dbg_tap_pkg::ST_EXIT1_DR : dbg_tap_pkg::ST_SHIFT_DR;
      dbg_tap_pkg::ST_EXIT1_DR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_UPD_DR : dbg_tap_pkg::ST_PAUSE_DR;
      dbg_tap_pkg::ST_PAUSE_DR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_EXIT2_DR : dbg_tap_pkg::ST_PAUSE_DR;
      dbg_tap_pkg::ST_EXIT2_DR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_UPD_DR : dbg_tap_pkg::ST_SHIFT_DR;
      dbg_tap_pkg::ST_UPD_DR, dbg_tap_pkg::ST_UPD_IR:
        nxt_state = mode_select ?
        dbg_tap_pkg::ST_SEL_DR : dbg_tap_pkg::ST_IDLE;
      dbg_tap_pkg::ST_SEL_IR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_RESET : dbg_tap_pkg::ST_CAP_IR;
      dbg_tap_pkg::ST_CAP_IR, dbg_tap_pkg::ST_SHIFT_IR:
        nxt_state = mode_select ?
        dbg_tap_pkg::ST_EXIT1_IR : dbg_tap_pkg::ST_SHIFT_IR;
      dbg_tap_pkg::ST_EXIT1_IR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_UPD_IR : dbg_tap_pkg::ST_PAUSE_IR;
      dbg_tap_pkg::ST_PAUSE_IR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_EXIT2_IR : dbg_tap_pkg::ST_PAUSE_IR;
      dbg_tap_pkg::ST_EXIT2_IR: nxt_state = mode_select ?
        dbg_tap_pkg::ST_UPD_IR : dbg_tap_pkg::ST_SHIFT_IR;
      default: nxt_state = dbg_tap_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_ff <= dbg_tap_pkg::ST_RESET;
    end else if (tc.step) begin
      state_ff <= nxt_state;
    end
  end

  assign tc.state = state_ff;
endmodule

// *** src/dbg_tap_port.sv ***
// Processor debug port: TAP, debug request, watchpoint and comms flags
//
// Functional notes
// R1 - Outputs from, inputs sampled on, rising edge; request out and chain feed are gates of inputs
// R2 - Outside logic synchronises asynchronous inputs first
// R3 - Receive flag high while receive buffer full
// R4 - Transmit flag high while transmit buffer empty
// R5 - Acknowledge high throughout debug state
// R6 - Breakpoint logic works only when enabled
// R7 - Output internal debug request to core
// R8 - External condition qualifies breakpoint matches
// R9 - Executed flag marks execute-stage completion
// R10 - Range match ignores unit enable bit
// R11 - Fetch breakpoint enters debug at execute
// R12 - Data watchpoint enters debug state
// R13 - Full configuration provides range and breakpoints
// R14 - Test reset clears debug state
// R15 - JTAG logic advances only on enable
// R16 - Instruction output changes in update-IR
// R17 - Chain number changes in update-DR
// R18 - Show TAP controller state
// R19 - Output enable low while shifting out
// R20 - Feed serial data to external chain
// R21 - External chain return low when absent
// R22 - IDCODE shifts out the identity input
// R23 - Clock may be stretched either phase
// R24 - Internal request is OR of both
`timescale 1ns/1ps
module dbg_tap_port #(
  parameter bit FULL_DEBUG = 1'b1 // Full debug configuration present
) (
  input wire logic CLK_SYS, // System clock, 50 MHz
  input wire logic RST, // Core reset, active high, asynchronous
  input wire logic DEBUG_TAP_RESET_N, // Test reset, active low
  input wire logic DEBUG_TCK_ENABLE, // Test clock enable
  input wire logic DEBUG_SERIAL_IN, // Serial test data in
  input wire logic DEBUG_MODE_SELECT, // Test mode select
  output logic DEBUG_SERIAL_OUT, // Serial test data out
  output logic SERIAL_OUT_DRIVE_EN_N, // Low while shifting out data
  output logic [3:0] TAP_INSTRUCTION_VIEW, // Loaded instruction
  output logic [4:0] SELECTED_SCAN_CHAIN_ID, // Selected chain number
  output logic [3:0] TAP_STATE_VIEW, // TAP controller state
  output logic EXT_CHAIN_SERIAL_FEED, // Data to external chain
  input wire logic EXT_CHAIN_SERIAL_RETURN, // Data from external chain
  input wire logic [31:0] TAP_IDENTITY_VALUE, // Identification code
  input wire logic DEBUG_LOGIC_ENABLE, // Enables breakpoint logic
  input wire logic EXTERNAL_DEBUG_REQUEST, // Request from debugger
  output logic INTERNAL_DEBUG_REQUEST, // Request as seen by core
  input wire logic [1:0] DEBUG_EXTERNAL_CONDITION, // Match qualifier
  input wire logic [1:0] WATCH_UNIT_HIT, // Raw unit compare hits
  output logic [1:0] WATCHPOINT_RANGE_MATCH, // Unit match, any enable
  input wire logic [1:0] WATCH_UNIT_ENABLE, // Unit enables
  input wire logic [1:0] WATCH_UNIT_COND, // Unit needs condition
  input wire logic EXTERNAL_INSTR_BREAKPOINT, // Fetch breakpoint
  input wire logic EXTERNAL_DATA_WATCHPOINT, // Data watchpoint
  input wire logic FETCH_DONE, // Instruction fetch ends this cycle
  input wire logic DATA_REQ_DONE, // Data request ends this cycle
  input wire logic EXEC_ADVANCE, // Fetched instruction reaches execute
  input wire logic EXEC_DONE, // Execute-stage instruction completes
  input wire logic DEBUG_EXIT, // Core leaves debug state (restart)
  input wire logic COMMS_RX_WRITE, // Debugger side wrote receive word
  input wire logic COMMS_RX_READ, // Core read receive word
  input wire logic COMMS_TX_WRITE, // Core wrote transmit word
  input wire logic COMMS_TX_READ, // Debugger side read transmit word
  output logic COMMS_RX_FULL_FLAG, // Receive buffer holds data
  output logic COMMS_TX_EMPTY_FLAG, // Transmit buffer empty
  output logic DEBUG_STATE_ACK, // Processor in debug state
  output logic INSTR_EXECUTED_FLAG // Execute-stage instruction done
);
  tap_ctrl_if tc ();
  logic [3:0] ir_ff;
  logic [3:0] ir_shift_ff;
  logic [4:0] sc_ff;
  logic [4:0] sc_shift_ff;
  logic [31:0] dr_shift_ff;
  logic [5:0] dcr_ff;
  logic tdo_ff;
  logic tdo_en_n_ff;
  logic rx_full_ff;
  logic tx_empty_ff;
  logic dbg_ack_ff;
  logic bkpt_pend_ff;
  logic exec_ff;
  logic [1:0] rng_ff;
  logic step;
  logic in_state;
  logic [1:0] unit_match;
  logic unit_fire;
  logic ext_ib;
  logic ext_dw;
  logic dr_sel_sc;
  logic dr_sel_dcr;
  logic dr_sel_ext;
  logic dr_sel_id;

  // Unit matches when hit and, if asked, the external condition agrees
  function automatic logic [1:0] qual_match(input logic [1:0] hit,
    input logic [1:0] need, input logic [1:0] cond);
    qual_match = hit & (~need | cond);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // TAP controller and registers

  assign step = DEBUG_TCK_ENABLE; // [R15]
  assign tc.step = step;

  tap_fsm u_fsm (
    .clk(CLK_SYS),
    .tap_rst_n(DEBUG_TAP_RESET_N),
    .mode_select(DEBUG_MODE_SELECT),
    .tc(tc)
  );

  function automatic logic is_state(input logic [3:0] s,
    input dbg_tap_pkg::tap_state_t t);
    is_state = (s == t);
  endfunction

  assign dr_sel_sc = (ir_ff == dbg_tap_pkg::INS_SCAN_N);
  assign dr_sel_id = (ir_ff == dbg_tap_pkg::INS_IDCODE);
  assign dr_sel_dcr = (ir_ff == dbg_tap_pkg::INS_INTEST) &&
    (sc_ff == dbg_tap_pkg::SC_DEBUG_CTRL);
  assign dr_sel_ext = (ir_ff == dbg_tap_pkg::INS_INTEST) &&
    (sc_ff == dbg_tap_pkg::SC_EXTERNAL);

  // Instruction shift and update
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin // [R14]
      ir_shift_ff <= dbg_tap_pkg::IR_RESET;
      ir_ff <= dbg_tap_pkg::IR_RESET;
    end else if (step) begin // [R15]
      if (is_state(tc.state, dbg_tap_pkg::ST_RESET)) begin
        ir_ff <= dbg_tap_pkg::IR_RESET;
      end else if (is_state(tc.state, dbg_tap_pkg::ST_CAP_IR)) begin
        ir_shift_ff <= 4'h1;
      end else if (is_state(tc.state, dbg_tap_pkg::ST_SHIFT_IR)) begin
        ir_shift_ff <= {DEBUG_SERIAL_IN, ir_shift_ff[3:1]};
      end else if (is_state(tc.state, dbg_tap_pkg::ST_UPD_IR)) begin
        ir_ff <= ir_shift_ff; // [R16]
      end
    end
  end

  // Data register shifts; one 32-bit shifter shared by all chains but the 5-bit scan chain select and the external chain
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      dr_shift_ff <= 32'h0000_0000;
    end else if (step) begin
      if (is_state(tc.state, dbg_tap_pkg::ST_CAP_DR)) begin
        if (dr_sel_id) begin
          dr_shift_ff <= TAP_IDENTITY_VALUE; // [R22]
        end else if (dr_sel_sc) begin
          dr_shift_ff <= {27'h0000000, sc_ff};
        end else if (dr_sel_dcr) begin
          dr_shift_ff <= {26'h0000000, dcr_ff};
        end else begin
          dr_shift_ff <= 32'h0000_0000;
        end
      end else if (is_state(tc.state, dbg_tap_pkg::ST_SHIFT_DR)) begin
        dr_shift_ff <= {DEBUG_SERIAL_IN, dr_shift_ff[31:1]};
      end
    end
  end

  // Scan chain select shifts in its own 5-bit register
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      sc_shift_ff <= dbg_tap_pkg::SC_RESET;
      sc_ff <= dbg_tap_pkg::SC_RESET;
    end else if (step && dr_sel_sc) begin
      if (is_state(tc.state, dbg_tap_pkg::ST_CAP_DR)) begin
        sc_shift_ff <= sc_ff;
      end else if (is_state(tc.state, dbg_tap_pkg::ST_SHIFT_DR)) begin
        sc_shift_ff <= {DEBUG_SERIAL_IN, sc_shift_ff[4:1]};
      end else if (is_state(tc.state, dbg_tap_pkg::ST_UPD_DR)) begin
        sc_ff <= sc_shift_ff; // [R17]
      end
    end
  end

  // Debug control register, loaded from the high shifter bits on update
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      dcr_ff <= dbg_tap_pkg::DCR_RESET; // [R14]
    end else if (step && dr_sel_dcr &&
      is_state(tc.state, dbg_tap_pkg::ST_UPD_DR)) begin
      dcr_ff <= dr_shift_ff[31:26];
    end
  end

  // Serial output, registered on a rising edge when step is high
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      tdo_ff <= 1'b0;
      tdo_en_n_ff <= 1'b1;
    end else if (step) begin
      if (is_state(tc.state, dbg_tap_pkg::ST_SHIFT_IR)) begin
        tdo_ff <= ir_shift_ff[0];
        tdo_en_n_ff <= 1'b0; // [R19]
      end else if (is_state(tc.state, dbg_tap_pkg::ST_SHIFT_DR)) begin
        tdo_en_n_ff <= 1'b0; // [R19]
        if (dr_sel_ext) begin
          tdo_ff <= EXT_CHAIN_SERIAL_RETURN; // [R21]
        end else if (dr_sel_sc) begin
          tdo_ff <= sc_shift_ff[0];
        end else begin
          tdo_ff <= dr_shift_ff[0]; // [R22]
        end
      end else begin
        tdo_ff <= 1'b0;
        tdo_en_n_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug state, breakpoints and watchpoints

  assign INTERNAL_DEBUG_REQUEST = EXTERNAL_DEBUG_REQUEST |
    dcr_ff[dbg_tap_pkg::DCR_DBGRQ_BIT]; // [R7] [R24]

  assign unit_match = qual_match(WATCH_UNIT_HIT, WATCH_UNIT_COND,
    DEBUG_EXTERNAL_CONDITION); // [R8]
  // Only enabled units fire, and only while the logic is enabled
  assign unit_fire = DEBUG_LOGIC_ENABLE &&
    |(unit_match & WATCH_UNIT_ENABLE); // [R6]
  assign ext_ib = FULL_DEBUG && DEBUG_LOGIC_ENABLE &&
    EXTERNAL_INSTR_BREAKPOINT; // [R13] [R6]
  assign ext_dw = FULL_DEBUG && DEBUG_LOGIC_ENABLE &&
    EXTERNAL_DATA_WATCHPOINT; // [R13] [R6]

  // Breakpoint caught at fetch end is held until execute
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      bkpt_pend_ff <= 1'b0;
    end else if (FETCH_DONE) begin
      bkpt_pend_ff <= ext_ib; // [R11]
    end else if (EXEC_ADVANCE) begin
      bkpt_pend_ff <= 1'b0;
    end
  end

  assign in_state = (EXEC_ADVANCE && bkpt_pend_ff) || // [R11]
    (DATA_REQ_DONE && ext_dw) || // [R12]
    unit_fire || INTERNAL_DEBUG_REQUEST;

  // Entry wins over exit in the same cycle so no event is lost
  always_ff @(posedge CLK_SYS or negedge DEBUG_TAP_RESET_N) begin
    if (!DEBUG_TAP_RESET_N) begin
      dbg_ack_ff <= 1'b0; // [R14]
    end else if (in_state) begin
      dbg_ack_ff <= 1'b1; // [R5]
    end else if (DEBUG_EXIT) begin
      dbg_ack_ff <= 1'b0;
    end
  end

  // Range match is raw: independent of unit enables
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rng_ff <= 2'h0;
      exec_ff <= 1'b0;
    end else begin
      rng_ff <= FULL_DEBUG ? unit_match : 2'h0; // [R10] [R13]
      exec_ff <= EXEC_DONE; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comms channel flags; set wins over clear

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_full_ff <= 1'b0;
    end else if (COMMS_RX_WRITE) begin
      rx_full_ff <= 1'b1; // [R3]
    end else if (COMMS_RX_READ) begin
      rx_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_empty_ff <= 1'b1;
    end else if (COMMS_TX_READ) begin
      tx_empty_ff <= 1'b1; // [R4]
    end else if (COMMS_TX_WRITE) begin
      tx_empty_ff <= 1'b0;
    end
  end

  // Every output is a flop or a plain gate of flops and inputs; nothing
  // depends on clock duty, so a stretched clock in either phase is safe
  assign DEBUG_SERIAL_OUT = tdo_ff; // [R1] [R23]
  assign SERIAL_OUT_DRIVE_EN_N = tdo_en_n_ff;
  assign TAP_INSTRUCTION_VIEW = ir_ff;
  assign SELECTED_SCAN_CHAIN_ID = sc_ff;
  assign TAP_STATE_VIEW = tc.state; // [R18]
  assign EXT_CHAIN_SERIAL_FEED = dr_sel_ext & DEBUG_SERIAL_IN; // [R20]
  assign WATCHPOINT_RANGE_MATCH = rng_ff;
  assign COMMS_RX_FULL_FLAG = rx_full_ff;
  assign COMMS_TX_EMPTY_FLAG = tx_empty_ff;
  assign DEBUG_STATE_ACK = dbg_ack_ff;
  assign INSTR_EXECUTED_FLAG = exec_ff;
endmodule

// *** verification/dbg_tap_props.sv ***
// Concurrent checks on the debug TAP port pins
`timescale 1ns/1ps
module dbg_tap_props (
  input wire logic CLK_SYS, // Clock
  input wire logic RST, // Core reset
  input wire logic DEBUG_TAP_RESET_N, // Test reset
  input wire logic DEBUG_TCK_ENABLE, // Step enable
  input wire logic [3:0] TAP_STATE_VIEW, // State
  input wire logic [3:0] TAP_INSTRUCTION_VIEW, // Instruction
  input wire logic [4:0] SELECTED_SCAN_CHAIN_ID, // Chain
  input wire logic EXTERNAL_DEBUG_REQUEST, // Request in
  input wire logic INTERNAL_DEBUG_REQUEST, // Request out
  input wire logic DEBUG_STATE_ACK, // Debug state
  input wire logic DEBUG_EXIT, // Restart
  input wire logic DEBUG_LOGIC_ENABLE, // Gate
  input wire logic EXTERNAL_DATA_WATCHPOINT, // Watchpoint
  input wire logic DATA_REQ_DONE, // Data cycle end
  input wire logic EXEC_DONE, // Execute done
  input wire logic INSTR_EXECUTED_FLAG, // Executed flag
  input wire logic COMMS_RX_WRITE, // Receive write
  input wire logic COMMS_RX_FULL_FLAG, // Receive full
  input wire logic [1:0] WATCH_UNIT_HIT, // Hits
  input wire logic [1:0] WATCH_UNIT_COND, // Need condition
  input wire logic [1:0] DEBUG_EXTERNAL_CONDITION, // Condition
  input wire logic [1:0] WATCHPOINT_RANGE_MATCH // Range match
);
  logic rst_any;
  logic [1:0] qual;
  // Either reset clears part of the state, so both mute the checks
  assign rst_any = RST | ~DEBUG_TAP_RESET_N;
  assign qual = WATCH_UNIT_HIT & (~WATCH_UNIT_COND | DEBUG_EXTERNAL_CONDITION);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (rst_any);
  //////////////////////////////////////////////////////////////////////////
  a_step_needs_enable: assert property (
    !DEBUG_TCK_ENABLE |=> $stable(TAP_STATE_VIEW))
    else $error("tap state moved without enable");
  a_ir_update_only: assert property (
    $changed(TAP_INSTRUCTION_VIEW) |->
      $past(TAP_STATE_VIEW) == 4'hD && $past(DEBUG_TCK_ENABLE))
    else $error("instruction changed outside update-ir");
  a_chain_update_only: assert property (
    $changed(SELECTED_SCAN_CHAIN_ID) |->
      $past(TAP_STATE_VIEW) == 4'h5 && $past(DEBUG_TCK_ENABLE))
    else $error("chain changed outside update-dr");
  a_request_or: assert property (
    EXTERNAL_DEBUG_REQUEST |-> INTERNAL_DEBUG_REQUEST)
    else $error("external request not passed inside");
  a_ack_holds: assert property (
    DEBUG_STATE_ACK && !DEBUG_EXIT |=> DEBUG_STATE_ACK)
    else $error("ack dropped without exit");
  a_watch_enters: assert property (
    DEBUG_LOGIC_ENABLE && EXTERNAL_DATA_WATCHPOINT && DATA_REQ_DONE
      |=> DEBUG_STATE_ACK)
    else $error("data watchpoint ignored");
  a_exec_follows: assert property (
    1'h1 |=> INSTR_EXECUTED_FLAG == $past(EXEC_DONE))
    else $error("executed flag not one cycle after done");
  a_range_qualified: assert property (
    1'h1 |=> WATCHPOINT_RANGE_MATCH == $past(qual))
    else $error("range match differs from qualified hits");
  a_rx_sets_full: assert property (
    COMMS_RX_WRITE |=> COMMS_RX_FULL_FLAG)
    else $error("receive flag not set by write");
  c_shift_dr: cover property (TAP_STATE_VIEW == 4'h2);
  c_ack_rise: cover property ($rose(DEBUG_STATE_ACK));
  c_range_both: cover property (WATCHPOINT_RANGE_MATCH == 2'h3);
endmodule
bind dbg_tap_port dbg_tap_props i_props (.*);

// *** verification/ext_chain_model.sv ***
// External scan chain hung off the debug port
`timescale 1ns/1ps
module ext_chain_model #(
  parameter int LEN = 4 // Chain length
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset, active high
  input wire logic step, // Shift enable
  input wire logic feed, // Serial in
  input wire logic present, // Chain fitted
  output logic ret // Serial return
);
  logic [LEN-1:0] sr_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_ff <= '0;
    end else if (step) begin
      sr_ff <= {sr_ff[LEN-2:0], feed};
    end
  end
  // An absent chain must read low, never a stale bit
  assign ret = present ? sr_ff[LEN-1] : 1'h0;
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the debug TAP port
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID_VAL = 32'h1234_5679; // Arbitrary value
  logic CLK_SYS = 1'h0, RST = 1'h1, DEBUG_TAP_RESET_N = 1'h0;
  logic DEBUG_TCK_ENABLE = 1'h0, DEBUG_SERIAL_IN = 1'h0;
  logic DEBUG_MODE_SELECT = 1'h0, DEBUG_LOGIC_ENABLE = 1'h0;
  logic EXTERNAL_DEBUG_REQUEST = 1'h0, EXTERNAL_INSTR_BREAKPOINT = 1'h0;
  logic EXTERNAL_DATA_WATCHPOINT = 1'h0, FETCH_DONE = 1'h0;
  logic DATA_REQ_DONE = 1'h0, EXEC_ADVANCE = 1'h0, EXEC_DONE = 1'h0;
  logic DEBUG_EXIT = 1'h0, COMMS_RX_WRITE = 1'h0, COMMS_RX_READ = 1'h0;
  logic COMMS_TX_WRITE = 1'h0, COMMS_TX_READ = 1'h0;
  logic [1:0] DEBUG_EXTERNAL_CONDITION = 2'h0, WATCH_UNIT_HIT = 2'h0;
  logic [1:0] WATCH_UNIT_ENABLE = 2'h0, WATCH_UNIT_COND = 2'h0;
  logic [31:0] TAP_IDENTITY_VALUE = ID_VAL;
  logic DEBUG_SERIAL_OUT, SERIAL_OUT_DRIVE_EN_N, EXT_CHAIN_SERIAL_FEED;
  logic EXT_CHAIN_SERIAL_RETURN, INTERNAL_DEBUG_REQUEST, DEBUG_STATE_ACK;
  logic COMMS_RX_FULL_FLAG, COMMS_TX_EMPTY_FLAG, INSTR_EXECUTED_FLAG;
  logic [3:0] TAP_INSTRUCTION_VIEW, TAP_STATE_VIEW;
  logic [4:0] SELECTED_SCAN_CHAIN_ID;
  logic [1:0] WATCHPOINT_RANGE_MATCH;
  logic [31:0] got;
  logic [3:0] pre_ir;
  logic [4:0] pre_sc;
  logic en_hi;
  int mismatches = 0, n_checks = 0, cycles = 0;

  dbg_tap_port #(.FULL_DEBUG(1'h1)) i_dut (.*);
  ext_chain_model #(.LEN(4)) i_chain (.clk(CLK_SYS), .rst(RST),
    .step(DEBUG_TCK_ENABLE), .feed(EXT_CHAIN_SERIAL_FEED), .present(1'h1),
    .ret(EXT_CHAIN_SERIAL_RETURN));

  always #10 CLK_SYS = ~CLK_SYS;
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  // Inputs change 1 ns after an edge, already synchronous
  task automatic step(input logic m, d);
    DEBUG_MODE_SELECT = m;
    DEBUG_SERIAL_IN = d;
    DEBUG_TCK_ENABLE = 1'h1;
    tick(1);
  endtask
  // From Idle through one IR or DR scan of n bits, LSB first, to Idle
  task automatic scan(input bit ir, input logic [31:0] v, input int n);
    step(1'h1, 1'h0);
    if (ir) step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    step(1'h0, 1'h0);
    en_hi = 1'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i]);
      got[i] = DEBUG_SERIAL_OUT;
      en_hi = en_hi | SERIAL_OUT_DRIVE_EN_N;
    end
    step(1'h1, 1'h0);
    pre_ir = TAP_INSTRUCTION_VIEW;
    pre_sc = SELECTED_SCAN_CHAIN_ID;
    step(1'h0, 1'h0);
    DEBUG_TCK_ENABLE = 1'h0;
  endtask
  task automatic leave_debug;
    DEBUG_EXIT = 1'h1;
    tick(1);
    DEBUG_EXIT = 1'h0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    RST = 1'h0;
    DEBUG_TAP_RESET_N = 1'h1;
    chk("state", dbg_tap_pkg::ST_RESET, TAP_STATE_VIEW);
    chk("ir", dbg_tap_pkg::INS_IDCODE, TAP_INSTRUCTION_VIEW);
    chk("chain", dbg_tap_pkg::SC_RESET, SELECTED_SCAN_CHAIN_ID);
    chk("rx tx ack", 3'h2, {COMMS_RX_FULL_FLAG, COMMS_TX_EMPTY_FLAG,
      DEBUG_STATE_ACK});
    step(1'h0, 1'h0);
    DEBUG_TCK_ENABLE = 1'h0;
    DEBUG_MODE_SELECT = 1'h1;
    tick(3);
    chk("state", dbg_tap_pkg::ST_IDLE, TAP_STATE_VIEW);
    scan(1'h0, 32'h0, 32);
    chk("idcode", ID_VAL, got);
    chk("drive_en_n", 1'h0, en_hi);
    scan(1'h1, {28'h0, dbg_tap_pkg::INS_SCAN_N}, 4);
    chk("ir pre", dbg_tap_pkg::INS_IDCODE, pre_ir);
    chk("ir", dbg_tap_pkg::INS_SCAN_N, TAP_INSTRUCTION_VIEW);
    scan(1'h0, {27'h0, dbg_tap_pkg::SC_DEBUG_CTRL}, 5);
    chk("chain pre", dbg_tap_pkg::SC_RESET, pre_sc);
    chk("chain", dbg_tap_pkg::SC_DEBUG_CTRL, SELECTED_SCAN_CHAIN_ID);
    scan(1'h1, {28'h0, dbg_tap_pkg::INS_INTEST}, 4);
    // Control bit 1 sits at shifter bit 27 after a full 32-bit scan
    scan(1'h0, 32'h0800_0000, 32);
    chk("req ctrl", 1'h1, INTERNAL_DEBUG_REQUEST);
    tick(1);
    chk("ack", 1'h1, DEBUG_STATE_ACK);
    scan(1'h0, 32'h0, 32);
    chk("req off", 1'h0, INTERNAL_DEBUG_REQUEST);
    chk("ack held", 1'h1, DEBUG_STATE_ACK);
    leave_debug();
    chk("ack", 1'h0, DEBUG_STATE_ACK);
    scan(1'h1, {28'h0, dbg_tap_pkg::INS_SCAN_N}, 4);
    scan(1'h0, {27'h0, dbg_tap_pkg::SC_EXTERNAL}, 5);
    scan(1'h1, {28'h0, dbg_tap_pkg::INS_INTEST}, 4);
    DEBUG_SERIAL_IN = 1'h1;
    #1;
    chk("feed", 1'h1, EXT_CHAIN_SERIAL_FEED);
    // Four-stage chain: each bit returns four shifts after it went in
    scan(1'h0, 32'h0000_00A5, 12);
    chk("ext chain", 32'h0000_0A50, {20'h0, got[11:0]});
    EXTERNAL_DEBUG_REQUEST = 1'h1;
    #1;
    chk("req ext", 1'h1, INTERNAL_DEBUG_REQUEST);
    tick(1);
    EXTERNAL_DEBUG_REQUEST = 1'h0;
    chk("ack", 1'h1, DEBUG_STATE_ACK);
    leave_debug();
    EXTERNAL_DATA_WATCHPOINT = 1'h1;
    WATCH_UNIT_HIT = 2'h3;
    WATCH_UNIT_ENABLE = 2'h3;
    for (int g = 0; g < 2; g++) begin
      DEBUG_LOGIC_ENABLE = g[0];
      DATA_REQ_DONE = 1'h1;
      tick(1);
      DATA_REQ_DONE = 1'h0;
      chk("ack watch", g[0], DEBUG_STATE_ACK);
    end
    {EXTERNAL_DATA_WATCHPOINT, WATCH_UNIT_HIT, WATCH_UNIT_ENABLE} = 5'h00;
    leave_debug();
    EXTERNAL_INSTR_BREAKPOINT = 1'h1;
    FETCH_DONE = 1'h1;
    tick(1);
    {EXTERNAL_INSTR_BREAKPOINT, FETCH_DONE} = 2'h0;
    tick(2);
    chk("ack early", 1'h0, DEBUG_STATE_ACK);
    EXEC_ADVANCE = 1'h1;
    tick(1);
    EXEC_ADVANCE = 1'h0;
    chk("ack bkpt", 1'h1, DEBUG_STATE_ACK);
    leave_debug();
    DEBUG_LOGIC_ENABLE = 1'h0;
    EXEC_DONE = 1'h1;
    tick(1);
    EXEC_DONE = 1'h0;
    chk("executed", 1'h1, INSTR_EXECUTED_FLAG);
    {WATCH_UNIT_HIT, WATCH_UNIT_COND} = 4'hE;
    for (int e = 0; e < 4; e++) begin
      DEBUG_EXTERNAL_CONDITION = e[1:0];
      tick(1);
      chk("range", {e[1], 1'h1}, WATCHPOINT_RANGE_MATCH);
    end
    {COMMS_RX_WRITE, COMMS_TX_WRITE} = 2'h3;
    tick(1);
    {COMMS_RX_WRITE, COMMS_TX_WRITE} = 2'h0;
    chk("rx tx", 2'h2, {COMMS_RX_FULL_FLAG, COMMS_TX_EMPTY_FLAG});
    {COMMS_RX_READ, COMMS_TX_READ} = 2'h3;
    tick(1);
    {COMMS_RX_READ, COMMS_TX_READ} = 2'h0;
    chk("rx tx", 2'h1, {COMMS_RX_FULL_FLAG, COMMS_TX_EMPTY_FLAG});
    tally_and_finish();
  end
endmodule
